/* File: pkg/rail_status_pkg.sv */
/*
  Constants for the rail monitor status register bank: read selectors,
  bit positions of both status registers, reset values and the index of
  each monitored condition in the synchronised condition vector.
  Assumes a single core clock and a synchronous power-on reset.
*/
package rail_status_pkg;

  // Read selector values carried with a read command
  localparam logic       SEL_RAIL_MON      = 1'b0;
  localparam logic       SEL_SAFETY        = 1'b1;

  // Reset values of both status registers and the 5 V enable bit
  localparam logic [7:0] RAIL_MON_RST      = 8'h00;
  localparam logic [7:0] SAFETY_RST        = 8'h00;
  localparam logic       CAN_EN_RST        = 1'b0;

  // Field positions, rail voltage monitor status
  localparam int         B_PRE_OV          = 7;
  localparam int         B_PRE_UV          = 6;
  localparam int         B_CAN_OV          = 5;
  localparam int         B_CAN_UV          = 4;
  localparam int         B_IO_OV           = 3;
  localparam int         B_IO_UV           = 2;
  localparam int         B_CORE_OV         = 1;
  localparam int         B_CORE_UV         = 0;

  // Field positions, regulator safety status (bit 3 reserved, reads zero)
  localparam int         B_CAN_ILIM        = 7;
  localparam int         B_IO_ILIM         = 6;
  localparam int         B_SENS_UV         = 5;
  localparam int         B_SENS_OV         = 4;
  localparam int         B_RSV             = 3;
  localparam int         B_SENS_OT         = 2;
  localparam int         B_CAN_OT          = 1;
  localparam int         B_IO_OT           = 0;

  // Diagnostic multiplexer code that routes the sensor current limit
  localparam logic [3:0] DIAG_SENS_ILIM    = 4'h5;

  // Condition vector indices; bits 7..0 mirror the rail monitor layout
  localparam int         NCOND             = 17;
  localparam int         C_CAN_ILIM        = 8;
  localparam int         C_IO_ILIM         = 9;
  localparam int         C_SENS_UV         = 10;
  localparam int         C_SENS_OV         = 11;
  localparam int         C_SENS_ILIM       = 12;
  localparam int         C_SENS_OT         = 13;
  localparam int         C_CAN_OT          = 14;
  localparam int         C_IO_OT           = 15;
  localparam int         C_PRE_OT          = 16;

endpackage : rail_status_pkg

/* File: hw/rail_monitor_status_regs.sv */
/*
  Rail monitor status register bank: two read-only 8-bit status
  registers that track live rail conditions, the overtemperature
  gating of the regulator enables, and the diagnostic mux tap.
  Assumes the conditions come from asynchronous comparators, and that
  read commands, the 5 V enable write and configuration bits come from
  the serial interface logic on the same core clock.
*/
`timescale 1ns/1ns

// Contract
// - Both registers reset to zero, read only
// - Bit 6 tracks preregulator undervoltage
// - Bit 2 tracks I/O rail undervoltage
// - Bit 0 tracks core rail undervoltage
// - Overvoltage flags clear when condition goes
// - Undervoltage flags track live, never latch
// - Safety bit 7 tracks 5 V current limit
// - 5 V limit flag reads one when disabled
// - Safety bit 6 tracks I/O current limit
// - Current limit flags clear when condition goes
// - Safety bit 5 tracks sensor undervoltage
// - Safety bit 4 tracks sensor overvoltage
// - Bit 3 reserved; sensor limit on diag
// - Sensor overtemp flag holds sensor regulator off
// - Allowed 5 V overtemp disables, clears enable
// - Masked 5 V overtemp only sets flag
// - I/O overtemp flag holds I/O regulator off
// - Overtemperature flags clear when condition goes
// - I/O or prereg overtemp always disables I/O
module rail_monitor_status_regs
  import rail_status_pkg::*;
(
  input  wire logic       I_CORE_CLK,        // Core clock, 25 MHz
  input  wire logic       I_RST_B,           // Internal power-on reset, sync, low
  input  wire logic       I_PRE_OV,          // Preregulator overvoltage comparator
  input  wire logic       I_PRE_UV,          // Preregulator undervoltage comparator
  input  wire logic       I_CAN_OV,          // 5 V rail overvoltage comparator
  input  wire logic       I_CAN_UV,          // 5 V rail undervoltage comparator
  input  wire logic       I_IO_OV,           // I/O rail overvoltage comparator
  input  wire logic       I_IO_UV,           // I/O rail undervoltage comparator
  input  wire logic       I_CORE_OV,         // Core rail overvoltage comparator
  input  wire logic       I_CORE_UV,         // Core rail undervoltage comparator
  input  wire logic       I_CAN_ILIM,        // 5 V rail current limit exceeded
  input  wire logic       I_IO_ILIM,         // I/O rail current limit exceeded
  input  wire logic       I_SENS_UV,         // Sensor rail undervoltage
  input  wire logic       I_SENS_OV,         // Sensor rail overvoltage
  input  wire logic       I_SENS_ILIM,       // Sensor rail current limit
  input  wire logic       I_SENS_OT,         // Sensor rail overtemperature
  input  wire logic       I_CAN_OT,          // 5 V rail overtemperature
  input  wire logic       I_IO_OT,           // I/O rail overtemperature
  input  wire logic       I_PRE_OT,          // Preregulator overtemperature
  input  wire logic       I_READ_CMD,        // Read command strobe, one cycle
  input  wire logic       I_READ_SEL,        // 0 rail monitor, 1 safety status
  input  wire logic       I_CAN_EN_WR,       // Write strobe for 5 V enable bit
  input  wire logic       I_CAN_EN_WDATA,    // Value written to 5 V enable bit
  input  wire logic       I_CAN_OT_SHDN,     // 5 V overtemp shutdown allowed
  input  wire logic [3:0] I_DIAG_SEL,        // Diagnostic digital mux select
  output logic      [7:0] O_READ_DATA,       // Read answer data
  output logic            O_READ_VALID,      // Read answer strobe, one cycle
  output logic            O_CAN_EN,          // 5 V enable bit, read back
  output logic            O_CAN_RAIL_EN,     // 5 V regulator enable
  output logic            O_IO_RAIL_EN,      // I/O regulator enable
  output logic            O_SENS_RAIL_EN,    // Sensor regulator enable
  output logic            O_DIAGNOSTIC_MUX_OUTPUT         // Diagnostic mux output
);

  logic [NCOND-1:0] cond_raw;
  logic [NCOND-1:0] sync1;
  logic [NCOND-1:0] sync2;
  logic [NCOND-1:0] sync3;
  logic [NCOND-1:0] cond;
  logic [7:0]       rail_mon;
  logic [7:0]       safety;
  logic             can_en;

  // Gather comparator outputs; low byte matches the rail monitor layout
  assign cond_raw = {I_PRE_OT, I_IO_OT, I_CAN_OT, I_SENS_OT, I_SENS_ILIM,
                     I_SENS_OV, I_SENS_UV, I_IO_ILIM, I_CAN_ILIM,
                     I_PRE_OV, I_PRE_UV, I_CAN_OV, I_CAN_UV,
                     I_IO_OV, I_IO_UV, I_CORE_OV, I_CORE_UV};

  // Three-stage synchroniser per condition; a change is accepted only
  // when stages two and three agree, which also rejects one-cycle glitches
  genvar g;
  generate
    for (g = 0; g < NCOND; g++)
    begin : g_sync
      always_ff @(posedge I_CORE_CLK)
      begin
        if (!I_RST_B)
        begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          sync3[g] <= 1'b0;
          cond[g]  <= 1'b0;
        end
        else
        begin
          sync1[g] <= cond_raw[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          if (sync2[g] == sync3[g])
            cond[g] <= sync3[g];
        end
      end
    end
  endgenerate

  // Rail monitor flags follow the filtered conditions, no latching
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RST_B)
      rail_mon <= RAIL_MON_RST;
    else
      rail_mon <= cond[7:0];
  end

  // Safety flags; the 5 V limit bit is forced high while disabled
  // because the limit comparator output is meaningless then
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RST_B)
      safety <= SAFETY_RST;
    else
    begin
      safety[B_CAN_ILIM] <= cond[C_CAN_ILIM] | ~can_en;
      safety[B_IO_ILIM]  <= cond[C_IO_ILIM];
      safety[B_SENS_UV]  <= cond[C_SENS_UV];
      safety[B_SENS_OV]  <= cond[C_SENS_OV];
      safety[B_RSV]      <= 1'b0;
      safety[B_SENS_OT]  <= cond[C_SENS_OT];
      safety[B_CAN_OT]   <= cond[C_CAN_OT];
      safety[B_IO_OT]    <= cond[C_IO_OT];
    end
  end

  // 5 V enable bit; an allowed overtemperature wins over a software set
  // so that the regulator cannot be switched back on mid-event
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RST_B)
      can_en <= CAN_EN_RST;
    else if (I_CAN_OT_SHDN && cond[C_CAN_OT])
      can_en <= 1'b0;
    else if (I_CAN_EN_WR)
      can_en <= I_CAN_EN_WDATA;
  end

  // Regulator enables: I/O and sensor held off by their overtemp flags, I/O also by prereg overtemp; 5 V follows can_en
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RST_B)
    begin
      O_CAN_RAIL_EN  <= 1'b0;
      O_IO_RAIL_EN   <= 1'b0;
      O_SENS_RAIL_EN <= 1'b0;
      O_CAN_EN       <= 1'b0;
    end
    else
    begin
      O_CAN_RAIL_EN  <= can_en;
      O_IO_RAIL_EN   <= ~(safety[B_IO_OT] | cond[C_PRE_OT]);
      O_SENS_RAIL_EN <= ~safety[B_SENS_OT];
      O_CAN_EN       <= can_en;
    end
  end

  // Diagnostic mux tap for the sensor current limit
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RST_B)
      O_DIAGNOSTIC_MUX_OUTPUT <= 1'b0;
    else
      O_DIAGNOSTIC_MUX_OUTPUT <= (I_DIAG_SEL == DIAG_SENS_ILIM) & cond[C_SENS_ILIM];
  end

  // Read port; the answer is a copy, the flags are never touched here,
  // and there is deliberately no write path into either register
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RST_B)
    begin
      O_READ_DATA  <= 8'h00;
      O_READ_VALID <= 1'b0;
    end
    else
    begin
      O_READ_VALID <= I_READ_CMD;
      if (I_READ_CMD)
      begin
        if (I_READ_SEL == SEL_SAFETY)
          O_READ_DATA <= safety;
        else
          O_READ_DATA <= rail_mon;
      end
    end
  end

  // Checks
  a_reset_zero: assert property (@(posedge I_CORE_CLK)
    !I_RST_B |=> (rail_mon == 8'h00) && (safety == 8'h00))
    else $error("Status registers not zero after reset");

  a_rail_track: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    rail_mon == $past(cond[7:0]))
    else $error("Rail monitor flags do not follow conditions");

  a_uv_clears: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (!I_PRE_UV)[*6] |-> !rail_mon[B_PRE_UV])
    else $error("Preregulator undervoltage flag stuck");

  a_ilim_forced: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    !can_en |=> safety[B_CAN_ILIM])
    else $error("5 V limit flag not forced while disabled");

  a_rsv_zero: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    !safety[B_RSV])
    else $error("Reserved safety bit set");

  a_can_shutdown: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (I_CAN_OT_SHDN && cond[C_CAN_OT]) |=> !can_en ##1 !O_CAN_RAIL_EN)
    else $error("5 V overtemp did not disable regulator");

  a_can_masked: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (!I_CAN_OT_SHDN && !I_CAN_EN_WR) |=> can_en == $past(can_en))
    else $error("Masked 5 V overtemp changed enable");

  a_io_hold: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    safety[B_IO_OT] |=> !O_IO_RAIL_EN)
    else $error("I/O regulator on during overtemp");

  a_sens_hold: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    safety[B_SENS_OT] |=> !O_SENS_RAIL_EN)
    else $error("Sensor regulator on during overtemp");

  a_pre_ot_io: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    cond[C_PRE_OT] |=> !O_IO_RAIL_EN)
    else $error("Preregulator overtemp left I/O on");

  a_read_data: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (I_READ_CMD && I_READ_SEL == SEL_SAFETY) |=>
      O_READ_VALID && (O_READ_DATA == $past(safety)))
    else $error("Safety read answer wrong");

  c_read_rail: cover property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    I_READ_CMD && I_READ_SEL == SEL_RAIL_MON && rail_mon != 8'h00);

  c_can_trip: cover property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    can_en ##1 !can_en && safety[B_CAN_OT]);

  c_io_trip: cover property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    O_IO_RAIL_EN ##1 !O_IO_RAIL_EN);

  c_diag_tap: cover property (@(posedge I_CORE_CLK) disable iff (!I_RST_B)
    O_DIAGNOSTIC_MUX_OUTPUT);

endmodule : rail_monitor_status_regs

/* File: test/status_reader.sv */
/*
  Controller-side model that reads the status registers.
  Assumes the bank answers a one-cycle read strobe within a few cycles.
*/
`timescale 1ns/1ns
module status_reader
  import rail_status_pkg::*;
(
  input  wire logic       i_clk,   // Core clock
  input  wire logic       i_valid, // Read answer strobe
  input  wire logic [7:0] i_data,  // Read answer data
  output logic            o_cmd,   // Read command strobe
  output logic            o_sel    // Register selector
);
  // Idle: no command pending
  initial
  begin
    o_cmd = 1'b0;
    o_sel = SEL_RAIL_MON;
  end

  // Strobe stands one cycle; the answer wait is bounded so a dead bank shows
  task automatic read(input logic sel, output logic [7:0] data, output logic ok);
    ok = 1'b0;
    data = 8'h00;
    o_cmd = 1'b1;
    o_sel = sel;
    @(negedge i_clk);
    o_cmd = 1'b0;
    repeat (4)
    begin
      if (!ok && i_valid === 1'b1)
      begin
        ok = 1'b1;
        data = i_data;
      end
      if (!ok)
        @(negedge i_clk);
    end
  endtask : read
endmodule : status_reader

/* File: test/test_rail_monitor_status_regs.sv */
/*
  Self-checking bench for the rail status bank.
  Assumes the package constants and 5-edge condition filtering.
*/
`timescale 1ns/1ns
module test_rail_monitor_status_regs
  import rail_status_pkg::*;
;
  logic        clk;
  logic        rst_b;
  logic [16:0] cnd;          // Condition levels by package index
  logic        can_wr;
  logic        can_wd;
  logic        ot_shdn;
  logic [3:0]  diag_sel;
  logic        rd_cmd;
  logic        rd_sel;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic        can_en;
  logic        can_rail;
  logic        io_rail;
  logic        sens_rail;
  logic        diag;
  int          n_mismatch;
  int          total_checks;
  int          cyc;

  rail_monitor_status_regs dut_u (
    .I_CORE_CLK(clk), .I_RST_B(rst_b),
    .I_PRE_OV(cnd[B_PRE_OV]), .I_PRE_UV(cnd[B_PRE_UV]),
    .I_CAN_OV(cnd[B_CAN_OV]), .I_CAN_UV(cnd[B_CAN_UV]),
    .I_IO_OV(cnd[B_IO_OV]), .I_IO_UV(cnd[B_IO_UV]),
    .I_CORE_OV(cnd[B_CORE_OV]), .I_CORE_UV(cnd[B_CORE_UV]),
    .I_CAN_ILIM(cnd[C_CAN_ILIM]), .I_IO_ILIM(cnd[C_IO_ILIM]),
    .I_SENS_UV(cnd[C_SENS_UV]), .I_SENS_OV(cnd[C_SENS_OV]),
    .I_SENS_ILIM(cnd[C_SENS_ILIM]), .I_SENS_OT(cnd[C_SENS_OT]),
    .I_CAN_OT(cnd[C_CAN_OT]), .I_IO_OT(cnd[C_IO_OT]), .I_PRE_OT(cnd[C_PRE_OT]),
    .I_READ_CMD(rd_cmd), .I_READ_SEL(rd_sel), .I_CAN_EN_WR(can_wr),
    .I_CAN_EN_WDATA(can_wd), .I_CAN_OT_SHDN(ot_shdn), .I_DIAG_SEL(diag_sel),
    .O_READ_DATA(rd_data), .O_READ_VALID(rd_valid), .O_CAN_EN(can_en),
    .O_CAN_RAIL_EN(can_rail), .O_IO_RAIL_EN(io_rail),
    .O_SENS_RAIL_EN(sens_rail), .O_DIAGNOSTIC_MUX_OUTPUT(diag));

  status_reader reader_u (.i_clk(clk), .i_valid(rd_valid), .i_data(rd_data),
    .o_cmd(rd_cmd), .o_sel(rd_sel));

  // Free-running core clock
  always #20 clk = ~clk;

  task results;
    $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  // Cut a hang short; the full run needs well under 2000 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_mismatch++;
      results();
    end
  end

  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk

  task rdchk(input logic sel, input logic [7:0] exp, input string nm);
    logic [7:0] d;
    logic       ok;
    reader_u.read(sel, d, ok);
    chk({nm, " answered"}, {7'h00, ok}, 8'h01);
    chk(nm, d, exp);
  endtask : rdchk

  // Eight cycles covers the five-edge filter with margin
  task setc(input int idx, input logic v);
    cnd[idx] = v;
    repeat (8) @(negedge clk);
  endtask : setc

  task wr_en(input logic v);
    can_wr = 1'b1;
    can_wd = v;
    @(negedge clk);
    can_wr = 1'b0;
    repeat (4) @(negedge clk);
  endtask : wr_en

  task t_reset;
    rdchk(SEL_RAIL_MON, 8'h00, "rail after reset");
    rdchk(SEL_SAFETY, 8'h80, "safety after reset");
    $display("reset test done");
  endtask : t_reset

  task t_rail;
    for (int i = 0; i < 8; i++)
    begin
      setc(i, 1'b1);
      rdchk(SEL_RAIL_MON, 8'h01 << i, "rail set");
      rdchk(SEL_RAIL_MON, 8'h01 << i, "rail reread");
      setc(i, 1'b0);
      rdchk(SEL_RAIL_MON, 8'h00, "rail clear");
    end
    $display("rail test done");
  endtask : t_rail

  task t_safety;
    int idx [4];
    idx = '{C_CAN_ILIM, C_IO_ILIM, C_SENS_UV, C_SENS_OV};
    wr_en(1'b1);
    rdchk(SEL_SAFETY, 8'h00, "safety enabled");
    for (int i = 0; i < 4; i++)
    begin
      setc(idx[i], 1'b1);
      rdchk(SEL_SAFETY, 8'h80 >> i, "safety set");
      setc(idx[i], 1'b0);
      rdchk(SEL_SAFETY, 8'h00, "safety clear");
    end
    diag_sel = DIAG_SENS_ILIM;
    setc(C_SENS_ILIM, 1'b1);
    rdchk(SEL_SAFETY, 8'h00, "reserved bit");
    chk("diag selected", {7'h00, diag}, 8'h01);
    diag_sel = 4'h0;
    repeat (3) @(negedge clk);
    chk("diag other", {7'h00, diag}, 8'h00);
    setc(C_SENS_ILIM, 1'b0);
    $display("safety test done");
  endtask : t_safety

  task t_overtemp;
    setc(C_SENS_OT, 1'b1);
    rdchk(SEL_SAFETY, 8'h04, "sensor ot");
    chk("sensor rail", {7'h00, sens_rail}, 8'h00);
    setc(C_SENS_OT, 1'b0);
    chk("sensor rail back", {7'h00, sens_rail}, 8'h01);
    setc(C_IO_OT, 1'b1);
    rdchk(SEL_SAFETY, 8'h01, "io ot");
    chk("io rail", {7'h00, io_rail}, 8'h00);
    setc(C_IO_OT, 1'b0);
    rdchk(SEL_SAFETY, 8'h00, "ot clear");
    setc(C_PRE_OT, 1'b1);
    chk("io rail prereg", {7'h00, io_rail}, 8'h00);
    setc(C_PRE_OT, 1'b0);
    chk("io rail back", {7'h00, io_rail}, 8'h01);
    ot_shdn = 1'b0;
    setc(C_CAN_OT, 1'b1);
    rdchk(SEL_SAFETY, 8'h02, "can ot masked");
    chk("can rail masked", {6'h00, can_en, can_rail}, 8'h03);
    setc(C_CAN_OT, 1'b0);
    ot_shdn = 1'b1;
    setc(C_CAN_OT, 1'b1);
    chk("can shut", {6'h00, can_en, can_rail}, 8'h00);
    rdchk(SEL_SAFETY, 8'h82, "can ot shut");
    wr_en(1'b1);
    chk("write in ot", {7'h00, can_en}, 8'h00);
    setc(C_CAN_OT, 1'b0);
    rdchk(SEL_SAFETY, 8'h80, "can ot gone");
    wr_en(1'b1);
    chk("can reenabled", {6'h00, can_en, can_rail}, 8'h03);
    $display("overtemp test done");
  endtask : t_overtemp

  // Reset in mid-run with a condition standing: the first read after
  // release must see the cleared register, not the live condition
  task t_rst_mid;
    setc(B_CORE_UV, 1'b1);
    rdchk(SEL_RAIL_MON, 8'h01, "core uv before reset");
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    rdchk(SEL_RAIL_MON, 8'h00, "rail at release");
    rdchk(SEL_SAFETY, 8'h80, "safety at release");
    repeat (8) @(negedge clk);
    rdchk(SEL_RAIL_MON, 8'h01, "core uv after reset");
    setc(B_CORE_UV, 1'b0);
    rdchk(SEL_RAIL_MON, 8'h00, "core uv gone");
    $display("mid reset test done");
  endtask : t_rst_mid

  // Main sequence; inputs change only at falling edges
  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    cnd = 17'h00000;
    can_wr = 1'b0;
    can_wd = 1'b0;
    ot_shdn = 1'b0;
    diag_sel = 4'h0;
    n_mismatch = 0;
    total_checks = 0;
    cyc = 0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    t_reset();
    t_rail();
    t_safety();
    t_overtemp();
    t_rst_mid();
    results();
  end
endmodule : test_rail_monitor_status_regs
